/* File: lvd_pkg.sv */
// constants and register map for the low-voltage detect control block
package lvd_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam logic [15:0] CTRL_ADDR = 16'hF730;
  localparam logic [15:0] STAT_ADDR = 16'hF731;
  localparam logic [15:0] IMASK_ADDR = 16'hF732;
  localparam logic [15:0] ISTAT_ADDR = 16'hF733;
  localparam logic [15:0] PRESC_LO_ADDR = 16'hF734;
  localparam logic [15:0] PRESC_HI_ADDR = 16'hF735;
  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_SEL_BIT = 3;
  localparam int CTRL_RST_EN_BIT = 2;
  localparam int CTRL_FALL_IE_BIT = 1;
  localparam int CTRL_RISE_IE_BIT = 0;
  localparam int STAT_FALL_BIT = 1;
  localparam int STAT_RISE_BIT = 0;
  localparam int EV_FALL = 0;
  localparam int EV_RISE = 1;
  localparam int EV_RESET = 2;
  localparam int NUM_EV = 3;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_MASK = 8'h8F;
  localparam int PRESC_W = 13;
  typedef enum logic [1:0] {LVD_IDLE, LVD_NORMAL, LVD_LOW} lvd_state_t;
endpackage : lvd_pkg

/* File: lvd_prescaler.sv */
// free-running system prescaler
`timescale 1ns/1ps
module lvd_prescaler
  import lvd_pkg::*;
#(
  parameter int WIDTH = PRESC_W
) (
  input wire logic core_clk,
  input wire logic reset,
  output logic [WIDTH-1:0] count
);
  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;

  always_comb begin
    count_d = count_q + {{(WIDTH-1){1'b0}}, 1'b1};
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

  assign count = count_q;
endmodule : lvd_prescaler

/* File: lvd_ctrl.sv */
// low-voltage detect control, flags, interrupt and reset request
`timescale 1ns/1ps
module lvd_ctrl
  import lvd_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic below_fall_level,
  input wire logic above_rise_level,
  input wire logic below_reset_low,
  input wire logic below_reset_high,
  output logic detector_enable,
  output logic ext_interrupt_zero,
  output logic brownout_reset,
  output logic irq
);
  logic [7:0] ctrl_q, ctrl_d;
  logic [1:0] stat_q, stat_d;
  logic [NUM_EV-1:0] imask_q, imask_d;
  logic [NUM_EV-1:0] istat_q, istat_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  lvd_state_t state_q, state_d;
  logic [PRESC_W-1:0] presc;
  logic en, sel, rst_en, fall_ie, rise_ie;
  logic fall_ev, rise_ev, below_reset;
  logic [NUM_EV-1:0] ev;
  logic [1:0] stat_set;

  lvd_prescaler #(.WIDTH(PRESC_W)) u_presc (
    .core_clk(core_clk),
    .reset(reset),
    .count(presc)
  );

  assign en = ctrl_q[CTRL_EN_BIT];
  assign sel = ctrl_q[CTRL_SEL_BIT];
  assign rst_en = ctrl_q[CTRL_RST_EN_BIT];
  assign fall_ie = ctrl_q[CTRL_FALL_IE_BIT];
  assign rise_ie = ctrl_q[CTRL_RISE_IE_BIT];
  assign detector_enable = en;

  assign below_reset = sel ? below_reset_high : below_reset_low;

  always_comb begin
    state_d = state_q;
    fall_ev = 1'b0;
    rise_ev = 1'b0;
    case (state_q)
      LVD_IDLE: begin
        if (en) begin
          state_d = below_fall_level ? LVD_LOW : LVD_NORMAL;
        end
      end
      LVD_NORMAL: begin
        if (!en) begin
          state_d = LVD_IDLE;
        end else if (below_fall_level) begin
          fall_ev = 1'b1;
          state_d = LVD_LOW;
        end
      end
      LVD_LOW: begin
        if (!en) begin
          state_d = LVD_IDLE;
        end else if (below_reset) begin
          state_d = LVD_IDLE;
        end else if (above_rise_level) begin
          rise_ev = 1'b1;
          state_d = LVD_NORMAL;
        end
      end
      default: begin
        state_d = LVD_IDLE;
      end
    endcase
  end

  assign brownout_reset = en && rst_en && below_reset;

  always_comb begin
    stat_set = 2'b00;
    stat_set[STAT_FALL_BIT] = fall_ev;
    stat_set[STAT_RISE_BIT] = rise_ev && rise_ie;
    stat_d = stat_q;
    if (reg_wr && reg_addr == STAT_ADDR) begin
      stat_d = stat_q & reg_wdata[1:0];
    end
    stat_d = stat_d | stat_set;
  end

  // fall and rise enable gates
  // requests stay pending until the handler clears
  assign ext_interrupt_zero = (stat_q[STAT_FALL_BIT] && fall_ie)
                           || (stat_q[STAT_RISE_BIT] && rise_ie);

  assign ev = {brownout_reset, rise_ev, fall_ev};

  always_comb begin
    ctrl_d = ctrl_q;
    imask_d = imask_q;
    istat_d = istat_q;
    // control write is how software cancels detection
    if (reg_wr && reg_addr == CTRL_ADDR) begin
      ctrl_d = reg_wdata & CTRL_MASK;
    end else if (reg_wr && reg_addr == IMASK_ADDR) begin
      imask_d = reg_wdata[NUM_EV-1:0];
    end else if (reg_wr && reg_addr == ISTAT_ADDR) begin
      istat_d = istat_q & ~reg_wdata[NUM_EV-1:0];
    end
    // event set beats write-one clear
    istat_d = istat_d | ev;
  end

  assign irq = |(istat_q & imask_q);

  always_comb begin
    rdata_d = '0;
    if (reg_rd) begin
      if (reg_addr == CTRL_ADDR) begin
        rdata_d = ctrl_q;
      end else if (reg_addr == STAT_ADDR) begin
        rdata_d = {6'h00, stat_q};
      end else if (reg_addr == IMASK_ADDR) begin
        rdata_d = {5'h00, imask_q};
      end else if (reg_addr == ISTAT_ADDR) begin
        rdata_d = {5'h00, istat_q};
      end else if (reg_addr == PRESC_LO_ADDR) begin
        rdata_d = presc[7:0];
      end else if (reg_addr == PRESC_HI_ADDR) begin
        rdata_d = {3'h0, presc[PRESC_W-1:8]};
      end else begin
        rdata_d = '0;
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ctrl_q <= CTRL_RESET;
      stat_q <= 2'b00;
      imask_q <= '0;
      istat_q <= '0;
      rdata_q <= '0;
      state_q <= LVD_IDLE;
    end else begin
      ctrl_q <= ctrl_d;
      stat_q <= stat_d;
      imask_q <= imask_d;
      istat_q <= istat_d;
      rdata_q <= rdata_d;
      state_q <= state_d;
    end
  end

  assign reg_rdata = rdata_q;
endmodule : lvd_ctrl

/* File: lvd_supply.sv */
// supply comparator model, supply level given in millivolts
`timescale 1ns/1ps
module lvd_supply (
  input wire logic [12:0] mv,
  output logic below_fall_level,
  output logic above_rise_level,
  output logic below_reset_low,
  output logic below_reset_high
);
  assign below_fall_level = mv <= 13'hE74;
  assign above_rise_level = mv >= 13'hFA0;
  assign below_reset_low = mv <= 13'h8FC;
  assign below_reset_high = mv <= 13'hE10;
endmodule : lvd_supply

/* File: lvd_ctrl_properties.sv */
// port checker for the low-voltage detect control block
`timescale 1ns/1ps
module lvd_ctrl_chk
  import lvd_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic below_fall_level,
  input wire logic above_rise_level,
  input wire logic below_reset_high,
  input wire logic detector_enable,
  input wire logic ext_interrupt_zero,
  input wire logic brownout_reset
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  wire logic cause = reg_wr | below_fall_level | above_rise_level;
  wire logic cw = reg_wr && reg_addr == CTRL_ADDR;
  sequence s_ctrl_wr; cw; endsequence
  sequence s_ctrl_rd; reg_rd && reg_addr == CTRL_ADDR; endsequence
  property p_en_set; s_ctrl_wr |=> detector_enable == $past(reg_wdata[7]);
  endproperty
  property p_en_hold; !cw |=> $stable(detector_enable); endproperty
  property p_rst; brownout_reset |-> detector_enable && below_reset_high;
  endproperty
  property p_rdz; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
  property p_unm; reg_rd && reg_addr == 16'hF7FF |=> reg_rdata == 8'h00;
  endproperty
  property p_ext_hold; ext_interrupt_zero && !reg_wr |=> ext_interrupt_zero;
  endproperty
  property p_ext_cause;
    $rose(ext_interrupt_zero) |-> $past(cause) || $past(cause, 2);
  endproperty
  property p_rd_ctrl; s_ctrl_wr ##1 !reg_wr ##1 s_ctrl_rd
    |=> reg_rdata == ($past(reg_wdata, 3) & CTRL_MASK); endproperty
  a_en_set: assert property (p_en_set)
    else $error("enable bit wrong");
  a_en_hold: assert property (p_en_hold)
    else $error("enable moved");
  a_rst: assert property (p_rst)
    else $error("reset without cause");
  a_rdz: assert property (p_rdz)
    else $error("read data not idle");
  a_unm: assert property (p_unm)
    else $error("unmapped read not zero");
  a_ext_hold: assert property (p_ext_hold)
    else $error("request dropped");
  a_ext_cause: assert property (p_ext_cause)
    else $error("request without event");
  a_rd_ctrl: assert property (p_rd_ctrl)
    else $error("control readback wrong");
endmodule : lvd_ctrl_chk
bind lvd_ctrl lvd_ctrl_chk u_chk (.*);

/* File: test_lvd_ctrl.sv */
// self-checking bench for the low-voltage detect control block
`timescale 1ns/1ps
module test_lvd_ctrl;
  import lvd_pkg::*;
  logic core_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, a, b;
  logic [12:0] mv = 13'h1388;
  logic below_fall_level, above_rise_level, below_reset_low;
  logic below_reset_high, detector_enable, ext_interrupt_zero;
  logic brownout_reset, irq;
  int n_errors = 0, n_compared = 0;
  always #2 core_clk = ~core_clk;
  lvd_supply u_sup (.*);
  lvd_ctrl dut (.*);
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_compared++;
    if (s !== e) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [15:0] ad, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [15:0] ad, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic rdc(input logic [15:0] ad, input logic [7:0] e);
    rd(ad, a);
    chk(a, e);
  endtask : rdc
  // comparator outputs settle well inside three cycles
  task automatic supply(input logic [12:0] v);
    @(posedge core_clk);
    mv <= v;
    repeat (3) @(posedge core_clk);
    #1;
  endtask : supply
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  initial begin
    repeat (5) @(posedge core_clk);
    reset <= 1'b0;
    rdc(CTRL_ADDR, 8'h00);
    rdc(STAT_ADDR, 8'h00);
    wr(CTRL_ADDR, 8'hFF);
    rdc(CTRL_ADDR, 8'h8F);
    rdc(16'hF7FF, 8'h00);
    rd(PRESC_LO_ADDR, b);
    rd(PRESC_LO_ADDR, a);
    chk(a - b, 8'h02);
    $display("registers done");
    wr(CTRL_ADDR, 8'h83);
    wr(IMASK_ADDR, 8'h07);
    supply(13'hDAC);
    chk(ext_interrupt_zero, 1'b1);
    chk(irq, 1'b1);
    rdc(STAT_ADDR, 8'h02);
    supply(13'h1004);
    rdc(STAT_ADDR, 8'h03);
    rdc(ISTAT_ADDR, 8'h03);
    wr(IMASK_ADDR, 8'h00);
    chk(irq, 1'b0);
    wr(IMASK_ADDR, 8'h07);
    wr(ISTAT_ADDR, 8'h03);
    chk(irq, 1'b0);
    wr(STAT_ADDR, 8'h00);
    chk(ext_interrupt_zero, 1'b0);
    wr(CTRL_ADDR, 8'h80);
    supply(13'hDAC);
    chk(ext_interrupt_zero, 1'b0);
    supply(13'h1004);
    rdc(STAT_ADDR, 8'h02);
    $display("events done");
    supply(13'hBB8);
    wr(CTRL_ADDR, 8'h84);
    chk(brownout_reset, 1'b0);
    wr(CTRL_ADDR, 8'h8C);
    chk(brownout_reset, 1'b1);
    supply(13'h7D0);
    wr(CTRL_ADDR, 8'h84);
    chk(brownout_reset, 1'b1);
    wr(CTRL_ADDR, 8'h80);
    chk(brownout_reset, 1'b0);
    rdc(ISTAT_ADDR, 8'h07);
    wr(CTRL_ADDR, 8'h00);
    chk(detector_enable, 1'b0);
    $display("reset done");
    complete_run();
  end
endmodule : test_lvd_ctrl
